// ===== hdl/iwd_decoder.sv
// Instruction word decoder: sorts each 12-bit word into a format, extracts
// operand fields and sets the instruction length in instruction cycles.
// Assumes words arrive from logic on clk_sys; one oscillator period per clock.
`timescale 1ns/10ps
module iwd_decoder (
  input wire logic clk_sys,
  input wire logic reset,
  input wire logic instr_valid,
  input wire logic [iwd_pkg::IWD_WORD_W-1:0] instr_word,
  input wire logic cond_true,
  output logic instr_ready,
  output iwd_pkg::iwd_dec_s dec_out,
  output logic dec_valid,
  output logic [1:0] exec_cycles,
  output logic [1:0] phase,
  output logic cycle_end
);
  import iwd_pkg::*;

  iwd_state_s st_q;
  iwd_state_s st_d;
  iwd_dec_s dec_c;

  // --------------------------------------------------------------------
  // Field extraction
  // --------------------------------------------------------------------
  always_comb begin
    dec_c = '0;
    dec_c.opcode = instr_word[11:8];
    // Five-bit register number; the two upper address bits stay zero
    dec_c.file_addr[6:5] = 2'h0;
    dec_c.file_addr[4:0] = instr_word[IWD_FILE_LSB +: IWD_FILE_W];
    dec_c.dest_file = instr_word[IWD_DEST_POS];
    dec_c.bit_num = instr_word[IWD_BIT_LSB +: IWD_BIT_W];
    dec_c.bit_mask = 8'h01 << dec_c.bit_num;
    if (instr_word[11:10] == 2'h0) begin
      dec_c.fmt = IWD_FMT_BYTE;
      // No bit field here; cleared so those word bits cannot leak
      dec_c.bit_num = 3'h0;
      dec_c.bit_mask = 8'h00;
      dec_c.cond_test = (instr_word[9:6] == 4'hb) ||
                        (instr_word[9:6] == 4'hf);
    end else if (instr_word[11:10] == 2'h1) begin
      dec_c.fmt = IWD_FMT_BIT;
      dec_c.dest_file = 1'b1;
      dec_c.cond_test = instr_word[9];
    end else begin
      dec_c.fmt = IWD_FMT_LIT;
      // No register operand; cleared so literal bits cannot leak
      dec_c.file_addr = 7'h00;
      dec_c.dest_file = 1'b0;
      dec_c.bit_num = 3'h0;
      dec_c.bit_mask = 8'h00;
      if (instr_word[11:9] == 3'h5) begin
        dec_c.jump_instruction = 1'b1;
        dec_c.literal = instr_word[IWD_JMP_W-1:0];
      end else begin
        dec_c.literal = {1'b0, instr_word[IWD_LIT_W-1:0]};
      end
      // Call, return and jump change the program counter
      dec_c.pc_change = (instr_word[11:10] == 2'h2);
    end
  end

  // --------------------------------------------------------------------
  // Sequencer
  // --------------------------------------------------------------------
  always_comb begin
    st_d = st_q;
    st_d.phase = st_q.phase + 2'h1;
    // Words are taken only in the last period of a cycle, and only
    // once the running word has no further cycle to spend; a word
    // offered at any other time is simply ignored
    if (st_q.phase == IWD_PHASE_LAST) begin
      if (st_q.busy && st_q.cyc_left != IWD_CYC_ONE) begin
        st_d.cyc_left = st_q.cyc_left - 2'h1;
      end else if (instr_valid) begin
        st_d.busy = 1'b1;
        st_d.dec = dec_c;
        st_d.cycles = IWD_CYC_ONE;
        if (dec_c.pc_change || (dec_c.cond_test && cond_true)) begin
          st_d.cycles = IWD_CYC_TWO;
        end
        st_d.cyc_left = st_d.cycles;
      end else begin
        // Nothing offered: fall idle
        st_d.busy = 1'b0;
        st_d.cyc_left = 2'h0;
      end
    end
  end

  always_ff @(posedge clk_sys or posedge reset) begin
    if (reset) begin
      st_q <= '0;
    end else begin
      st_q <= st_d;
    end
  end

  // --------------------------------------------------------------------
  // Outputs
  // --------------------------------------------------------------------

  assign instr_ready = (st_q.phase == IWD_PHASE_LAST) &&
                       (!st_q.busy || st_q.cyc_left == IWD_CYC_ONE);
  assign dec_out = st_q.dec;
  assign dec_valid = st_q.busy;
  assign exec_cycles = st_q.cycles;
  assign phase = st_q.phase;
  assign cycle_end = (st_q.phase == IWD_PHASE_LAST);

  // --------------------------------------------------------------------
  // Checks
  // --------------------------------------------------------------------
  a_phase_wraps: assert property (@(posedge clk_sys) disable iff (reset)
    st_q.phase == 2'h3 |=> st_q.phase == 2'h0 ##3 st_q.phase == 2'h3)
    else $error("phase does not repeat every four clocks");
  a_file_range: assert property (@(posedge clk_sys) disable iff (reset)
    dec_c.file_addr <= IWD_FILE_MAX)
    else $error("file address out of range");
  a_file_low_bits: assert property (
    @(posedge clk_sys) disable iff (reset)
    dec_c.fmt != IWD_FMT_LIT |-> dec_c.file_addr[4:0] == instr_word[4:0])
    else $error("file field not low five bits");
  a_dest_select: assert property (@(posedge clk_sys) disable iff (reset)
    dec_c.fmt == IWD_FMT_BYTE |-> dec_c.dest_file == instr_word[5])
    else $error("destination bit mismatch");
  a_bit_onehot: assert property (@(posedge clk_sys) disable iff (reset)
    dec_c.fmt == IWD_FMT_BIT |-> $onehot(dec_c.bit_mask) &&
      dec_c.bit_mask[instr_word[7:5]])
    else $error("bit mask wrong");
  a_jump_literal: assert property (
    @(posedge clk_sys) disable iff (reset)
    dec_c.jump_instruction |-> dec_c.literal == instr_word[8:0])
    else $error("jump target wrong");
  a_lit_narrow: assert property (@(posedge clk_sys) disable iff (reset)
    dec_c.fmt == IWD_FMT_LIT && !dec_c.jump_instruction |->
      dec_c.literal == {1'b0, instr_word[7:0]})
    else $error("literal wrong");
  a_fmt_one: assert property (@(posedge clk_sys) disable iff (reset)
    dec_c.fmt == (instr_word[11] ? IWD_FMT_LIT :
      (instr_word[10] ? IWD_FMT_BIT : IWD_FMT_BYTE)))
    else $error("format class wrong");
  a_two_cycles: assert property (@(posedge clk_sys) disable iff (reset)
    instr_ready && instr_valid && dec_c.pc_change |=>
      exec_cycles == 2'h2 ##4 !instr_ready [*3] ##1 instr_ready)
    else $error("jump not two cycles");
  a_opcode_top: assert property (@(posedge clk_sys) disable iff (reset)
    dec_c.opcode == instr_word[11:8])
    else $error("opcode field wrong");
  a_bit_num: assert property (@(posedge clk_sys) disable iff (reset)
    dec_c.fmt == IWD_FMT_BIT |-> dec_c.bit_num == instr_word[7:5])
    else $error("bit number field wrong");
  a_jump_pc: assert property (@(posedge clk_sys) disable iff (reset)
    dec_c.jump_instruction |-> dec_c.pc_change && dec_c.fmt == IWD_FMT_LIT)
    else $error("jump not a program counter change");
  a_lit_no_test: assert property (@(posedge clk_sys) disable iff (reset)
    dec_c.fmt == IWD_FMT_LIT |-> !dec_c.cond_test)
    else $error("literal word marked as conditional test");

  // --------------------------------------------------------------------
  // Checks: unused fields and sequencing
  // --------------------------------------------------------------------

  a_byte_unused: assert property (@(posedge clk_sys) disable iff (reset)
    dec_c.fmt == IWD_FMT_BYTE |-> dec_c.bit_mask == 8'h00 &&
      dec_c.literal == 9'h000)
    else $error("byte format leaks unused fields");
  a_bit_unused: assert property (@(posedge clk_sys) disable iff (reset)
    dec_c.fmt == IWD_FMT_BIT |-> dec_c.literal == 9'h000)
    else $error("bit format leaks literal field");
  a_lit_unused: assert property (@(posedge clk_sys) disable iff (reset)
    dec_c.fmt == IWD_FMT_LIT |-> dec_c.file_addr == 7'h00 &&
      dec_c.bit_mask == 8'h00 && !dec_c.dest_file)
    else $error("literal format leaks register fields");
  a_take_loads: assert property (@(posedge clk_sys) disable iff (reset)
    instr_ready && instr_valid |=> dec_valid && dec_out == $past(dec_c))
    else $error("decoded word not registered on take");
  a_out_holds: assert property (@(posedge clk_sys) disable iff (reset)
    !(instr_ready && instr_valid) |=> $stable(dec_out))
    else $error("decoded word changed without a take");
  a_idle_drops: assert property (@(posedge clk_sys) disable iff (reset)
    instr_ready && !instr_valid |=> !dec_valid)
    else $error("busy flag stays up with nothing taken");
  a_one_cycle: assert property (@(posedge clk_sys) disable iff (reset)
    instr_ready && instr_valid && !dec_c.pc_change &&
      !(dec_c.cond_test && cond_true) |=>
      exec_cycles == 2'h1 ##3 instr_ready)
    else $error("single cycle word not released after four clocks");
  a_skip_two: assert property (@(posedge clk_sys) disable iff (reset)
    instr_ready && instr_valid && dec_c.cond_test && cond_true |=>
      exec_cycles == 2'h2 ##3 !instr_ready)
    else $error("true test not held for two cycles");
  a_cyc_legal: assert property (@(posedge clk_sys) disable iff (reset)
    dec_valid |-> exec_cycles == IWD_CYC_ONE || exec_cycles == IWD_CYC_TWO)
    else $error("instruction length out of range");
  a_end_pulse: assert property (@(posedge clk_sys) disable iff (reset)
    cycle_end |=> !cycle_end [*3] ##1 cycle_end)
    else $error("cycle end not every fourth clock");
  a_ready_end: assert property (@(posedge clk_sys) disable iff (reset)
    instr_ready |-> cycle_end)
    else $error("word taken outside the last period");

  // --------------------------------------------------------------------
  // Coverage
  // --------------------------------------------------------------------

  c_byte: cover property (@(posedge clk_sys) disable iff (reset)
    instr_ready && instr_valid && dec_c.fmt == IWD_FMT_BYTE);
  c_skip: cover property (@(posedge clk_sys) disable iff (reset)
    instr_ready && instr_valid && dec_c.cond_test && cond_true);
  c_jump: cover property (@(posedge clk_sys) disable iff (reset)
    instr_ready && instr_valid && dec_c.jump_instruction);
  c_bit: cover property (@(posedge clk_sys) disable iff (reset)
    instr_ready && instr_valid && dec_c.fmt == IWD_FMT_BIT);
  c_back_to_back: cover property (@(posedge clk_sys) disable iff (reset)
    instr_ready && instr_valid ##4 instr_ready && instr_valid);

endmodule

// ===== hdl/iwd_pkg.sv
// Package for the instruction word decoder: field layout, formats, timing.
// Assumes a 12-bit instruction word from program memory.
package iwd_pkg;

  localparam int IWD_WORD_W = 12;
  localparam int IWD_FILE_LSB = 0;
  localparam int IWD_FILE_W = 5;
  localparam int IWD_DEST_POS = 5;
  localparam int IWD_BIT_LSB = 5;
  localparam int IWD_BIT_W = 3;
  localparam int IWD_LIT_W = 8;
  localparam int IWD_JMP_W = 9;
  localparam int IWD_PHASES = 4;
  localparam logic [1:0] IWD_PHASE_LAST = 2'h3;
  localparam logic [1:0] IWD_CYC_ONE = 2'h1;
  localparam logic [1:0] IWD_CYC_TWO = 2'h2;
  localparam logic [6:0] IWD_FILE_MAX = 7'h7f;

  typedef enum logic [1:0] {
    IWD_FMT_BYTE,
    IWD_FMT_BIT,
    IWD_FMT_LIT
  } iwd_fmt_e;

  typedef struct packed {
    iwd_fmt_e fmt;
    logic [3:0] opcode;
    logic [6:0] file_addr;
    logic dest_file;
    logic [2:0] bit_num;
    logic [7:0] bit_mask;
    logic [8:0] literal;
    logic jump_instruction;
    logic pc_change;
    logic cond_test;
  } iwd_dec_s;

  typedef struct packed {
    logic [1:0] phase;
    logic [1:0] cycles;
    logic [1:0] cyc_left;
    iwd_dec_s dec;
    logic busy;
  } iwd_state_s;

endpackage

// ===== dv/test_iwd_decoder.sv
// Self-checking bench for the instruction word decoder.
// Assumes iwd_pkg and iwd_decoder are compiled first; one clock domain.
`timescale 1ns/10ps
module test_iwd_decoder;
  import iwd_pkg::*;
  logic clk_sys = 1'b0;
  logic reset = 1'b1;
  logic instr_valid = 1'b0;
  logic [11:0] instr_word = 12'h000;
  logic cond_true = 1'b0;
  logic instr_ready, dec_valid, cycle_end;
  iwd_dec_s dec_out;
  logic [1:0] exec_cycles, phase;
  int num_errors = 0;
  int checked = 0;
  int cyc = 0;
  int last_take = -1;
  int last_len = 0;
  logic took = 1'b0;
  logic [12:0] notes[$];
  logic [31:0] exp_v, act_v, msk;
  logic [12:0] note_v;
  logic [9:0] exp_x, act_x;
  logic [1:0] exp_ph;
  int since = 0;
  logic [12:0] dir[11] = '{13'h0a05, 13'h01ff, 13'h01df, 13'h12ff, 13'h02ff,
    13'h17ff, 13'h04e0, 13'h0cff, 13'h09ab, 13'h08ab, 13'h0bff};
  always #5 clk_sys = ~clk_sys;
  iwd_decoder dut (.clk_sys(clk_sys), .reset(reset),
    .instr_valid(instr_valid), .instr_word(instr_word),
    .cond_true(cond_true), .instr_ready(instr_ready), .dec_out(dec_out),
    .dec_valid(dec_valid), .exec_cycles(exec_cycles), .phase(phase),
    .cycle_end(cycle_end));
  // ----------------------------------------
  // Expected decode of {cond, word}
  // ----------------------------------------
  function automatic logic [31:0] want(input logic [12:0] n);
    logic [11:0] w;
    logic tst;
    w = n[11:0];
    tst = (w[11:10] == 2'h0 && (w[9:6] == 4'hb || w[9:6] == 4'hf))
      || (w[11:10] == 2'h1 && w[9]);
    want = 32'h8000_0000;
    want[28:27] = (w[11:10] == 2'h2 || (tst && n[12])) ? 2'h2 : 2'h1;
    case (w[11:10])
      2'h0: want[26:17] = {IWD_FMT_BYTE, 2'h0, w[4:0], w[5]};
      2'h1: begin
        want[26:18] = {IWD_FMT_BIT, 2'h0, w[4:0]};
        want[16:9] = 8'h01 << w[7:5];
      end
      default: begin
        want[26:25] = IWD_FMT_LIT;
        want[8:0] = (w[11:9] == 3'h5) ? w[8:0] : {1'b0, w[7:0]};
      end
    endcase
  endfunction
  task automatic send(input logic [11:0] w, input logic ct);
    int n;
    instr_valid = 1'b1;
    instr_word = w;
    cond_true = ct;
    notes.push_back({ct, w});
    n = 0;
    do begin
      @(negedge clk_sys);
      n++;
    end while (instr_ready !== 1'b1 && n < 20);
    checked++;
    if (instr_ready !== 1'b1) begin
      num_errors++;
      $display("[FAIL] instr_ready exp 1 got %b", instr_ready);
    end
    @(posedge clk_sys);
    #1;
  endtask
  task automatic end_sim();
    $display("checks %0d errors %0d", checked, num_errors);
    if (num_errors == 0 && checked > 0)
      $display("RESULT: PASS");
    else
      $display("RESULT: FAIL");
    $finish;
  endtask
  // ----------------------------------------
  // Monitor: take spacing and decode
  // ----------------------------------------
  always @(posedge clk_sys) begin
    cyc <= cyc + 1;
    took <= instr_valid && instr_ready;
    if (!reset) begin
      since <= since + 1;
      exp_ph = 2'(since % 4);
      checked++;
      if ({phase, cycle_end} !== {exp_ph, exp_ph == 2'h3}) begin
        num_errors++;
        $display("[FAIL] phase,cycle_end exp %h got %h",
          {exp_ph, exp_ph == 2'h3}, {phase, cycle_end});
      end
    end
    if (!instr_valid) last_take <= -1;
    if (instr_valid && instr_ready) begin
      checked++;
      if (last_take >= 0 && cyc - last_take != 4 * last_len) begin
        num_errors++;
        $display("[FAIL] take gap exp %0d got %0d", 4 * last_len,
          cyc - last_take);
      end
      last_take <= cyc;
    end
    if (cyc > 3000) begin
      num_errors++;
      end_sim();
    end
  end
  always @(negedge clk_sys) if (took) begin
    note_v = notes.pop_front();
    exp_v = want(note_v);
    msk = exp_v[26:25] == 2'h0 ? 32'hfffe_0000 :
      exp_v[26:25] == 2'h1 ? 32'hfffd_fe00 : 32'hfe00_01ff;
    act_v = {dec_valid, phase, exec_cycles, dec_out.fmt, dec_out.file_addr,
      dec_out.dest_file, dec_out.bit_mask, dec_out.literal} & msk;
    last_len = exp_v[28:27];
    checked++;
    if (act_v !== exp_v) begin
      num_errors++;
      $display("[FAIL] decode exp %h got %h", exp_v, act_v);
    end
    exp_x = {note_v[11:8], (note_v[11:10] == 2'h1 ? note_v[7:5] : 3'h0),
      note_v[11:9] == 3'h5, note_v[11:10] == 2'h2, !note_v[11] &&
      note_v[9] && (note_v[10] || note_v[7:6] == 2'h3)};
    act_x = {dec_out.opcode, dec_out.bit_num, dec_out.jump_instruction,
      dec_out.pc_change, dec_out.cond_test};
    checked++;
    if (act_x !== exp_x) begin
      num_errors++;
      $display("[FAIL] opcode,bit,flags exp %h got %h", exp_x, act_x);
    end
  end
  initial begin
    void'($urandom(32'h5249));
    repeat (10) @(posedge clk_sys);
    #1 reset = 1'b0;
    foreach (dir[i]) send(dir[i][11:0], dir[i][12]);
    for (int i = 0; i < 60; i++) send(12'($urandom), 1'($urandom));
    instr_valid = 1'b0;
    repeat (12) @(posedge clk_sys);
    @(negedge clk_sys);
    checked++;
    if (dec_valid !== 1'b0) begin
      num_errors++;
      $display("[FAIL] dec_valid idle exp 0 got %b", dec_valid);
    end
    end_sim();
  end
endmodule
